//--- core/cfg_decoder_defs.svh
// Constants for the configuration word decoder: offsets, field positions, reset values
`ifndef CFG_DECODER_DEFS_SVH
`define CFG_DECODER_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CFG_ADDR_W 8
`define CFG_OFF_WORD0 8'h00
`define CFG_OFF_WORD1 8'h04
`define CFG_OFF_RUNCTL 8'h08
`define CFG_OFF_WDTCTL 8'h0C
`define CFG_OFF_STATUS 8'h10

// ----------------------------------------------------------------
// Protection and debug word fields
// ----------------------------------------------------------------
`define CFG_W0_CP_POS 28
`define CFG_W0_BWP_POS 24
`define CFG_W0_PWP_MSB 18
`define CFG_W0_PWP_LSB 10
`define CFG_W0_ICESEL_MSB 4
`define CFG_W0_ICESEL_LSB 3
`define CFG_W0_JTAG_POS 2
`define CFG_W0_DEBUG_MSB 1
`define CFG_W0_DEBUG_LSB 0
`define CFG_W0_RSVD_MASK 32'hEEF8_03E0
`define CFG_W0_RSVD_VALUE 32'h6EF8_03E0
`define CFG_PWP_ALL_ONES 9'h1FF
`define CFG_PWP_PAGE_SHIFT 10
`define CFG_DEBUG_OFF 2'h3

// ----------------------------------------------------------------
// Watchdog word fields
// ----------------------------------------------------------------
`define CFG_W1_WINSZ_MSB 25
`define CFG_W1_WINSZ_LSB 24
`define CFG_W1_HARDEN_POS 23
`define CFG_W1_WATCHDOG_WINDOW_DISABLE_POS 22
`define CFG_W1_PS_MSB 20
`define CFG_W1_PS_LSB 16
`define CFG_W1_RSVD_MASK 32'hFC00_0000
`define CFG_W1_RSVD_VALUE 32'hFC00_0000
`define CFG_PS_MAX 5'h14
`define CFG_WIN_25 3'h2
`define CFG_WIN_37 3'h3
`define CFG_WIN_50 3'h4
`define CFG_WIN_75 3'h6

// ----------------------------------------------------------------
// Runtime control bits and reset values
// ----------------------------------------------------------------
`define CFG_RUNCTL_JTAG_POS 3
`define CFG_WDTCTL_ON_POS 0
`define CFG_WDT_SW_RESET 1'b0
`define CFG_RDATA_RESET 32'h0000_0000
`define CFG_PIN_PAIR_BASE 4'h8

`endif

//--- core/cfg_decoder_pkg.sv
// Types shared by the configuration word decoder files
package cfg_decoder_pkg;

    // Load then run, one-hot
    typedef enum logic [1:0] {
        fsm_load = 2'b01,
        fsm_run = 2'b10
    } fsm_type;

    // Decoded flash protection
    typedef struct packed {
        logic code_protect;
        logic boot_write_protect;
        logic protect_all;
        logic [19:0] boundary;
    } flash_guard_type;

    // Decoded watchdog setup
    typedef struct packed {
        logic hard_enable;
        logic running;
        logic window_disable;
        logic [2:0] window_eighths;
        logic [4:0] postscale_exp;
    } wdt_cfg_type;

    // Whole state of the decoder top
    typedef struct packed {
        fsm_type fsm;
        logic [31:0] word0;
        logic [31:0] word1;
        logic jtag_en;
        logic wdt_sw_on;
        logic [31:0] rdata;
    } state_type;

endpackage

//--- core/flash_protect_decode.sv
// Program flash write-protect boundary decoder
`timescale 1ns/10ps
`default_nettype none
`include "cfg_decoder_defs.svh"

module flash_protect_decode #(
    parameter int PWP_BITS = 9,
    parameter logic [19:0] FLASH_BYTES = 20'h40000
) (
    // Captured protection word
    input wire logic [31:0] word0_i,
    // Decoded protection
    output cfg_decoder_pkg::flash_guard_type guard_o
);

    localparam logic [8:0] IMPL_MASK = 9'((1 << PWP_BITS) - 1);

    logic [8:0] field;
    logic [8:0] eff;
    logic [19:0] raw;

    // Missing upper bits read as ones on small variants
    assign field = word0_i[`CFG_W0_PWP_MSB:`CFG_W0_PWP_LSB];
    assign eff = field | ~IMPL_MASK;
    assign raw = {1'b0, `CFG_PWP_ALL_ONES - eff, 10'h000};

    // Boundary, clamped to implemented flash
    always_comb
    begin
        guard_o.code_protect = ~word0_i[`CFG_W0_CP_POS];
        guard_o.boot_write_protect = ~word0_i[`CFG_W0_BWP_POS];
        guard_o.protect_all = ((field & IMPL_MASK) == 9'h000);
        if (guard_o.protect_all || raw > FLASH_BYTES)
        begin
            guard_o.boundary = FLASH_BYTES;
        end
        else
        begin
            guard_o.boundary = raw;
        end
    end

endmodule // flash_protect_decode
`default_nettype wire

//--- core/wdt_config_decode.sv
// Watchdog configuration field decoder
`timescale 1ns/10ps
`default_nettype none
`include "cfg_decoder_defs.svh"

module wdt_config_decode (
    // Captured watchdog word and software request
    input wire logic [31:0] word1_i,
    input wire logic sw_on_i,
    // Decoded watchdog setup
    output cfg_decoder_pkg::wdt_cfg_type wdt_o
);

    logic [4:0] ps;

    assign ps = word1_i[`CFG_W1_PS_MSB:`CFG_W1_PS_LSB];

    // Window, enable policy and postscale
    always_comb
    begin
        wdt_o.hard_enable = word1_i[`CFG_W1_HARDEN_POS];
        wdt_o.running = word1_i[`CFG_W1_HARDEN_POS] | sw_on_i;
        wdt_o.window_disable = word1_i[`CFG_W1_WATCHDOG_WINDOW_DISABLE_POS];
        wdt_o.postscale_exp = (ps > `CFG_PS_MAX) ? `CFG_PS_MAX : ps;
        case (word1_i[`CFG_W1_WINSZ_MSB:`CFG_W1_WINSZ_LSB])
            2'h3: wdt_o.window_eighths = `CFG_WIN_25;
            2'h2: wdt_o.window_eighths = `CFG_WIN_37;
            2'h1: wdt_o.window_eighths = `CFG_WIN_50;
            default: wdt_o.window_eighths = `CFG_WIN_75;
        endcase
    end

endmodule // wdt_config_decode
`default_nettype wire

//--- core/device_config_word_decoder.sv
// Configuration word decoder top: capture, runtime registers, decoded outputs
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "cfg_decoder_defs.svh"

module device_config_word_decoder #(
    parameter int PWP_BITS = 9,
    parameter logic [19:0] FLASH_BYTES = 20'h40000
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Nonvolatile configuration words
    input wire logic [31:0] nvm_word0_i,
    input wire logic [31:0] nvm_word1_i,
    // Register port
    input wire logic [`CFG_ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_strobe_i,
    input wire logic rd_strobe_i,
    output logic [31:0] rdata_o,
    // Decoded protection and debug
    output cfg_decoder_pkg::flash_guard_type flash_guard_o,
    output logic [3:0] debug_pin_pair_o,
    output logic jtag_port_enable_o,
    output logic debugger_enable_o,
    // Decoded watchdog setup
    output cfg_decoder_pkg::wdt_cfg_type wdt_cfg_o,
    // Load status
    output logic config_loaded_o,
    output logic reserved_fault_o
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    generate
        if (PWP_BITS != 7 && PWP_BITS != 9)
        begin : g_bad_pwp
            $error("PWP_BITS must be 7 or 9");
        end
        if (FLASH_BYTES == 20'h00000 || FLASH_BYTES > 20'h7FC00)
        begin : g_bad_flash
            $error("FLASH_BYTES out of range");
        end
    endgenerate

    // ----------------------------------------------------------------
    // State and decoded signals
    // ----------------------------------------------------------------
    cfg_decoder_pkg::state_type state;
    cfg_decoder_pkg::state_type next_state;
    logic [1:0] debug_field;
    logic [31:0] status_word;
    logic [31:0] read_value;
    logic w0_ok;
    logic w1_ok;
    logic in_run;

    // Flash boundary decoder
    flash_protect_decode #(
        .PWP_BITS(PWP_BITS),
        .FLASH_BYTES(FLASH_BYTES)
    ) u_flash (
        .word0_i(state.word0),
        .guard_o(flash_guard_o)
    );

    // Watchdog field decoder
    wdt_config_decode u_wdt (
        .word1_i(state.word1),
        .sw_on_i(state.wdt_sw_on),
        .wdt_o(wdt_cfg_o)
    );

    // ----------------------------------------------------------------
    // Debug routing and status
    // ----------------------------------------------------------------
    assign in_run = (state.fsm == cfg_decoder_pkg::fsm_run);

    assign debug_field = flash_guard_o.code_protect ? `CFG_DEBUG_OFF
                                                    : state.word0[`CFG_W0_DEBUG_MSB:`CFG_W0_DEBUG_LSB];
    assign debugger_enable_o = ~debug_field[1];

    assign debug_pin_pair_o = `CFG_PIN_PAIR_BASE >> state.word0[`CFG_W0_ICESEL_MSB:`CFG_W0_ICESEL_LSB];

    assign jtag_port_enable_o = state.jtag_en;

    assign w0_ok = ((state.word0 & `CFG_W0_RSVD_MASK) == `CFG_W0_RSVD_VALUE);
    assign w1_ok = ((state.word1 & `CFG_W1_RSVD_MASK) == `CFG_W1_RSVD_VALUE);
    assign reserved_fault_o = ~(w0_ok & w1_ok);

    assign config_loaded_o = in_run;
    assign rdata_o = state.rdata;

    // Status word layout
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[0] = in_run;
        status_word[1] = flash_guard_o.code_protect;
        status_word[2] = debugger_enable_o;
        status_word[3] = wdt_cfg_o.running;
        status_word[4] = w0_ok;
        status_word[5] = w1_ok;
        status_word[11:8] = debug_pin_pair_o;
    end

    // ----------------------------------------------------------------
    // Register read decode
    // ----------------------------------------------------------------
    // Unmapped offsets read zero
    always_comb
    begin
        case (addr_i)
            `CFG_OFF_WORD0: read_value = state.word0;
            `CFG_OFF_WORD1: read_value = state.word1;
            `CFG_OFF_RUNCTL: read_value = 32'(state.jtag_en) << `CFG_RUNCTL_JTAG_POS;
            `CFG_OFF_WDTCTL: read_value = 32'(wdt_cfg_o.running) << `CFG_WDTCTL_ON_POS;
            `CFG_OFF_STATUS: read_value = status_word;
            default: read_value = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_state.rdata = rd_strobe_i ? read_value : `CFG_RDATA_RESET;
        if (!reset_n_i)
        begin
            next_state.fsm = cfg_decoder_pkg::fsm_load;
            next_state.word0 = nvm_word0_i;
            next_state.word1 = nvm_word1_i;
            next_state.jtag_en = nvm_word0_i[`CFG_W0_JTAG_POS];
            next_state.wdt_sw_on = `CFG_WDT_SW_RESET;
            next_state.rdata = `CFG_RDATA_RESET;
        end
        else
        begin
            case (state.fsm)
                cfg_decoder_pkg::fsm_load:
                begin
                    next_state.fsm = cfg_decoder_pkg::fsm_run;
                end
                cfg_decoder_pkg::fsm_run:
                begin
                    if (wr_strobe_i && addr_i == `CFG_OFF_RUNCTL)
                    begin
                        next_state.jtag_en = wdata_i[`CFG_RUNCTL_JTAG_POS];
                    end
                    if (wr_strobe_i && addr_i == `CFG_OFF_WDTCTL)
                    begin
                        next_state.wdt_sw_on = wdata_i[`CFG_WDTCTL_ON_POS];
                    end
                end
                default:
                begin
                    next_state.fsm = cfg_decoder_pkg::fsm_load;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk_i)
    begin
        state <= next_state;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // Runtime write to a given register
    sequence s_wr_runctl;
        in_run && wr_strobe_i && addr_i == `CFG_OFF_RUNCTL;
    endsequence

    sequence s_wr_wdtctl;
        in_run && wr_strobe_i && addr_i == `CFG_OFF_WDTCTL;
    endsequence

    sequence s_rd_status;
        rd_strobe_i && addr_i == `CFG_OFF_STATUS;
    endsequence

    a_code_protect_map: assert property (
        flash_guard_o.code_protect == !state.word0[`CFG_W0_CP_POS] && status_word[1] == flash_guard_o.code_protect)
        else $error("code protect does not follow word");

    a_boot_wp_map: assert property (
        flash_guard_o.boot_write_protect != state.word0[`CFG_W0_BWP_POS])
        else $error("boot write protect wrong");

    a_boundary_pages: assert property (
        !flash_guard_o.protect_all && PWP_BITS == 9 && flash_guard_o.boundary < FLASH_BYTES
        |-> flash_guard_o.boundary ==
            {1'b0, `CFG_PWP_ALL_ONES - state.word0[`CFG_W0_PWP_MSB:`CFG_W0_PWP_LSB], 10'h000})
        else $error("protect boundary wrong");

    a_protect_all_flash: assert property (
        state.word0[`CFG_W0_PWP_LSB+PWP_BITS-1:`CFG_W0_PWP_LSB] == '0
        |-> flash_guard_o.protect_all && flash_guard_o.boundary == FLASH_BYTES)
        else $error("all-zero field must protect all");

    a_small_variant: assert property (
        PWP_BITS == 7 && !flash_guard_o.protect_all
        |-> flash_guard_o.boundary <= 20'h1FC00)
        else $error("upper field bits not ignored");

    a_pin_pair_route: assert property (
        $onehot(debug_pin_pair_o)
        && (state.word0[`CFG_W0_ICESEL_MSB:`CFG_W0_ICESEL_LSB] == 2'h3) == debug_pin_pair_o[0]
        && (state.word0[`CFG_W0_ICESEL_MSB:`CFG_W0_ICESEL_LSB] == 2'h0) == debug_pin_pair_o[3])
        else $error("pin pair routing wrong");

    a_jtag_write: assert property (
        s_wr_runctl |=> jtag_port_enable_o == $past(wdata_i[`CFG_RUNCTL_JTAG_POS]))
        else $error("jtag write not taken");

    a_jtag_seed: assert property (
        $rose(in_run) |-> jtag_port_enable_o == state.word0[`CFG_W0_JTAG_POS])
        else $error("jtag not seeded from word");

    a_debug_forced: assert property (
        flash_guard_o.code_protect |-> !debugger_enable_o)
        else $error("debugger live under protection");

    a_window_size: assert property (
        state.word1[`CFG_W1_WINSZ_MSB:`CFG_W1_WINSZ_LSB] == 2'h0 |-> wdt_cfg_o.window_eighths == `CFG_WIN_75)
        else $error("window size wrong");

    a_wdt_hard_on: assert property (
        s_wr_wdtctl ##0 wdt_cfg_o.hard_enable |=> wdt_cfg_o.running [*2])
        else $error("watchdog stopped by software");

    a_wdt_soft_start: assert property (
        $rose(in_run) && !wdt_cfg_o.hard_enable |-> !wdt_cfg_o.running)
        else $error("watchdog not off at start");

    a_wdt_soft_on: assert property (
        s_wr_wdtctl ##0 wdata_i[`CFG_WDTCTL_ON_POS] |=> wdt_cfg_o.running)
        else $error("software cannot start watchdog");

    a_window_disable: assert property (
        wdt_cfg_o.window_disable == state.word1[`CFG_W1_WATCHDOG_WINDOW_DISABLE_POS])
        else $error("window disable wrong");

    a_postscale_clamp: assert property (
        state.word1[`CFG_W1_PS_MSB:`CFG_W1_PS_LSB] > `CFG_PS_MAX |-> wdt_cfg_o.postscale_exp == `CFG_PS_MAX)
        else $error("undefined postscale not clamped");

    a_words_hold: assert property (
        in_run |=> $stable(state.word0) && $stable(state.word1) && in_run)
        else $error("configuration changed after load");

    a_read_status: assert property (
        s_rd_status |=> rdata_o == $past(status_word) ##1 (rdata_o == 32'h0000_0000 || $past(rd_strobe_i)))
        else $error("read data timing wrong");

    // Read of the runtime control register
    sequence s_rd_runctl;
        rd_strobe_i && addr_i == `CFG_OFF_RUNCTL;
    endsequence

    a_runctl_readback: assert property (
        s_rd_runctl |=> rdata_o[`CFG_RUNCTL_JTAG_POS] == $past(jtag_port_enable_o))
        else $error("runtime jtag readback wrong");

    a_read_idle: assert property (
        !rd_strobe_i |=> rdata_o == 32'h0000_0000)
        else $error("read data not idle");

    a_load_then_run: assert property (
        reset_n_i && !in_run |=> in_run)
        else $error("load state not left");

    a_window_narrow: assert property (
        state.word1[`CFG_W1_WINSZ_MSB:`CFG_W1_WINSZ_LSB] == 2'h3 |-> wdt_cfg_o.window_eighths == `CFG_WIN_25)
        else $error("window quarter wrong");

    a_window_mid: assert property (
        (state.word1[`CFG_W1_WINSZ_MSB:`CFG_W1_WINSZ_LSB] != 2'h2 || wdt_cfg_o.window_eighths == `CFG_WIN_37)
        && (state.word1[`CFG_W1_WINSZ_MSB:`CFG_W1_WINSZ_LSB] != 2'h1 || wdt_cfg_o.window_eighths == `CFG_WIN_50))
        else $error("window middle codes wrong");

    a_pin_pair_mid: assert property (
        (state.word0[`CFG_W0_ICESEL_MSB:`CFG_W0_ICESEL_LSB] == 2'h2) == debug_pin_pair_o[1]
        && (state.word0[`CFG_W0_ICESEL_MSB:`CFG_W0_ICESEL_LSB] == 2'h1) == debug_pin_pair_o[2])
        else $error("pin pair two or three wrong");

    a_debug_field: assert property (
        !flash_guard_o.code_protect |-> debugger_enable_o == !state.word0[`CFG_W0_DEBUG_MSB])
        else $error("debugger field not decoded");

    a_jtag_hold: assert property (
        in_run && !(wr_strobe_i && addr_i == `CFG_OFF_RUNCTL) |=> $stable(jtag_port_enable_o))
        else $error("jtag changed unasked");

    a_wdt_hold: assert property (
        in_run && !(wr_strobe_i && addr_i == `CFG_OFF_WDTCTL) |=> $stable(wdt_cfg_o.running))
        else $error("watchdog changed unasked");

    a_postscale_pass: assert property (
        state.word1[`CFG_W1_PS_MSB:`CFG_W1_PS_LSB] <= `CFG_PS_MAX
        |-> wdt_cfg_o.postscale_exp == state.word1[`CFG_W1_PS_MSB:`CFG_W1_PS_LSB])
        else $error("defined postscale altered");

    a_hard_flag: assert property (
        wdt_cfg_o.hard_enable == state.word1[`CFG_W1_HARDEN_POS] && (!wdt_cfg_o.hard_enable || wdt_cfg_o.running))
        else $error("hard enable not honoured");

endmodule // device_config_word_decoder
`default_nettype wire

//--- tb/nvm_programmer_model.sv
// Programming device model that composes the stored configuration words
`timescale 1ns/10ps
`default_nettype none
`include "cfg_decoder_defs.svh"

module nvm_programmer_model (
    // Field values chosen by the bench
    input wire logic [31:0] fields0_i,
    input wire logic [31:0] fields1_i,
    input wire logic break_rsvd_i,
    // Stored words seen by the device
    output logic [31:0] word0_o,
    output logic [31:0] word1_o
);
    // Reserved bits forced; bit 31 flipped only when told to misbehave
    // word zero reserved pattern
    always_comb
    begin
        word0_o = (fields0_i & ~`CFG_W0_RSVD_MASK) | `CFG_W0_RSVD_VALUE;
        word1_o = (fields1_i & ~`CFG_W1_RSVD_MASK) | `CFG_W1_RSVD_VALUE;
        word0_o[31] = word0_o[31] ^ break_rsvd_i;
    end
endmodule // nvm_programmer_model
`default_nettype wire

//--- tb/device_config_word_decoder_tb_top.sv
// Self-checking bench for the configuration word decoder
`timescale 1ns/10ps
`default_nettype none
`include "cfg_decoder_defs.svh"

`define tb_check(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("mismatch %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module device_config_word_decoder_tb_top;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [31:0] fields0 = 32'h0;
    logic [31:0] fields1 = 32'h0;
    logic brk = 1'b0;
    wire logic [31:0] nvm_word0;
    wire logic [31:0] nvm_word1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_strobe_i = 1'b0;
    logic rd_strobe_i = 1'b0;
    logic [31:0] rdata_o;
    cfg_decoder_pkg::flash_guard_type flash_guard_o;
    logic [3:0] debug_pin_pair_o;
    logic jtag_port_enable_o;
    logic debugger_enable_o;
    cfg_decoder_pkg::wdt_cfg_type wdt_cfg_o;
    logic config_loaded_o;
    logic reserved_fault_o;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [31:0] exp_q[$];
    logic [31:0] exp_v;
    logic rd_d = 1'b0;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] f0;
    logic [31:0] f1;
    logic jtag_exp;
    logic soft_exp;
    logic [19:0] bnd;
    logic [2:0] win_tab[4] = '{`CFG_WIN_75, `CFG_WIN_50, `CFG_WIN_37, `CFG_WIN_25};

    // Clock at 125 MHz
    initial
    begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    nvm_programmer_model i_prog (
        .fields0_i(fields0),
        .fields1_i(fields1),
        .break_rsvd_i(brk),
        .word0_o(nvm_word0),
        .word1_o(nvm_word1)
    );

    device_config_word_decoder #(.PWP_BITS(9), .FLASH_BYTES(20'h40000)) i_dut (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .nvm_word0_i(nvm_word0),
        .nvm_word1_i(nvm_word1),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_strobe_i(wr_strobe_i),
        .rd_strobe_i(rd_strobe_i),
        .rdata_o(rdata_o),
        .flash_guard_o(flash_guard_o),
        .debug_pin_pair_o(debug_pin_pair_o),
        .jtag_port_enable_o(jtag_port_enable_o),
        .debugger_enable_o(debugger_enable_o),
        .wdt_cfg_o(wdt_cfg_o),
        .config_loaded_o(config_loaded_o),
        .reserved_fault_o(reserved_fault_o)
    );

    // Small variant: seven field bits, 128 KB flash
    cfg_decoder_pkg::flash_guard_type small_guard;
    if (1)
    begin : g_small
        device_config_word_decoder #(.PWP_BITS(7), .FLASH_BYTES(20'h20000)) i_dut (
            .ref_clk_i(ref_clk_i),
            .reset_n_i(reset_n_i),
            .nvm_word0_i(nvm_word0),
            .nvm_word1_i(nvm_word1),
            .addr_i(addr_i),
            .wdata_i(wdata_i),
            .wr_strobe_i(wr_strobe_i),
            .rd_strobe_i(rd_strobe_i),
            .rdata_o(),
            .flash_guard_o(small_guard),
            .debug_pin_pair_o(),
            .jtag_port_enable_o(),
            .debugger_enable_o(),
            .wdt_cfg_o(),
            .config_loaded_o(),
            .reserved_fault_o()
        );
    end

    // ----------------------------------------------------------------
    // Register bus tasks and expectations
    // ----------------------------------------------------------------
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_strobe_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_strobe_i <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk_i);
        exp_q.push_back(e);
        addr_i <= a;
        rd_strobe_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_strobe_i <= 1'b0;
    endtask

    function automatic logic [31:0] stat_exp();
        logic [31:0] s;
        s = 32'h0;
        s[0] = 1'b1;
        s[1] = ~w0[28];
        s[2] = w0[28] & ~w0[1];
        s[3] = w1[23] | soft_exp;
        s[4] = (w0 & `CFG_W0_RSVD_MASK) == `CFG_W0_RSVD_VALUE;
        s[5] = (w1 & `CFG_W1_RSVD_MASK) == `CFG_W1_RSVD_VALUE;
        s[11:8] = 4'h8 >> w0[4:3];
        return s;
    endfunction

    // Compares every decoded level output
    task automatic check_out();
        @(negedge ref_clk_i);
        bnd = (20'h001FF - {11'h0, w0[18:10]}) << 10;
        bnd = (bnd > 20'h40000) ? 20'h40000 : bnd;
        `tb_check("code_protect", ~w0[28], flash_guard_o.code_protect)
        `tb_check("boot_protect", ~w0[24], flash_guard_o.boot_write_protect)
        `tb_check("boundary", bnd, flash_guard_o.boundary)
        bnd = (w0[16:10] == 7'h00) ? 20'h20000 : (20'h0007F - {13'h0, w0[16:10]}) << 10;
        `tb_check("small_boundary", bnd, small_guard.boundary)
        `tb_check("protect_all", w0[18:10] == 9'h0, flash_guard_o.protect_all)
        `tb_check("pin_pair", 4'h8 >> w0[4:3], debug_pin_pair_o)
        `tb_check("jtag", jtag_exp, jtag_port_enable_o)
        `tb_check("debugger", w0[28] & ~w0[1], debugger_enable_o)
        `tb_check("window", win_tab[w1[25:24]], wdt_cfg_o.window_eighths)
        `tb_check("hard_en", w1[23], wdt_cfg_o.hard_enable)
        `tb_check("running", w1[23] | soft_exp, wdt_cfg_o.running)
        `tb_check("win_dis", w1[22], wdt_cfg_o.window_disable)
        `tb_check("postscale", (w1[20:16] > 5'h14) ? 5'h14 : w1[20:16], wdt_cfg_o.postscale_exp)
        `tb_check("loaded", 1'b1, config_loaded_o)
        `tb_check("rsvd_fault", (stat_exp() & 32'h30) != 32'h30, reserved_fault_o)
    endtask

    // Read data monitor: oldest note against the answer, zero otherwise
    always @(posedge ref_clk_i)
    begin
        rd_d <= rd_strobe_i;
    end

    always @(negedge ref_clk_i)
    begin
        if (rd_d)
        begin
            exp_v = exp_q.pop_front();
            `tb_check("rdata", exp_v, rdata_o)
        end
        else if (reset_n_i)
        begin
            `tb_check("rdata_idle", 32'h0, rdata_o)
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog against a hung run
    initial
    begin
        #200000;
        error_cnt++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Main sequence: one reset per word pair
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(43341));
        for (int i = 0; i < 6; i++)
        begin
            f0 = $urandom();
            f1 = $urandom();
            f0[4:3] = i[1:0];
            f1[25:24] = i[1:0];
            if (i == 0)
            begin
                f0[18:10] = 9'h000;
                f0[28] = 1'b0;
                f1[20:16] = 5'h1F;
                f1[23] = 1'b1;
            end
            if (i == 1)
            begin
                f0 = 32'hFFFF_FFFF;
                f1[20:16] = 5'h14;
                f1[23] = 1'b0;
            end
            if (i == 3)
                f0[18:10] = 9'h1FE;
            @(posedge ref_clk_i);
            fields0 <= f0;
            fields1 <= f1;
            brk <= (i == 2);
            reset_n_i <= 1'b0;
            repeat (15) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            `tb_check("loaded_in_reset", 1'b0, config_loaded_o)
            @(posedge ref_clk_i);
            reset_n_i <= 1'b1;
            w0 = nvm_word0;
            w1 = nvm_word1;
            jtag_exp = w0[2];
            soft_exp = 1'b0;
            repeat (2) @(posedge ref_clk_i);
            check_out();
            reg_rd(`CFG_OFF_WORD0, w0);
            reg_rd(`CFG_OFF_WORD1, w1);
            reg_rd(`CFG_OFF_STATUS, stat_exp());
            reg_rd(8'h2C, 32'h0);
            reg_wr(`CFG_OFF_WORD0, ~w0);
            reg_rd(`CFG_OFF_WORD0, w0);
            fields0 <= ~f0;
            fields1 <= ~f1;
            check_out();
            jtag_exp = ~jtag_exp;
            reg_wr(`CFG_OFF_RUNCTL, {28'h0, jtag_exp, 3'h0});
            check_out();
            reg_rd(`CFG_OFF_RUNCTL, {28'h0, jtag_exp, 3'h0});
            soft_exp = 1'b1;
            reg_wr(`CFG_OFF_WDTCTL, 32'h1);
            check_out();
            reg_rd(`CFG_OFF_WDTCTL, 32'h1);
            soft_exp = 1'b0;
            reg_wr(`CFG_OFF_WDTCTL, 32'h0);
            check_out();
            reg_rd(`CFG_OFF_WDTCTL, {31'h0, w1[23]});
            reg_rd(`CFG_OFF_STATUS, stat_exp());
            repeat (2) @(posedge ref_clk_i);
            $display("test %0d done", i);
        end
        final_report();
    end
endmodule // device_config_word_decoder_tb_top
`default_nettype wire
